// *** bench/qdc_cmd_props.sv ***
// Purpose: Port timing checks of the write command decoder.
// Assumes: Command byte follows the start with no gap.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ns
module qdc_cmd_props #(
  parameter int unsigned NV_PROG_CYCLES = qdc_pkg::NV_PROG_CYCLES
) (
  // Clock, reset and inputs.
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire qdc_pkg::qdc_rx_type i_rx,
  input wire logic i_output_load_n,
  // Outputs watched.
  input wire qdc_pkg::qdc_chan_type o_chan_in [4],
  input wire qdc_pkg::qdc_chan_type o_chan_out [4],
  input wire logic [2:0] o_bus_addr,
  input wire logic o_nv_write,
  input wire logic o_nv_ready_flag
);
  int unsigned busy_cnt;
  logic start_d;
  logic cmd_byte;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // A counter, not a repetition, bounds the long busy span.
  always_ff @(posedge i_sys_clk) begin
    start_d <= i_rx.start && !i_sys_rst;
    busy_cnt <= (i_sys_rst || o_nv_ready_flag) ? 0 : busy_cnt + 1;
  end
  // Command byte taken while ready.
  assign cmd_byte = start_d && i_rx.valid && o_nv_ready_flag;
  ready_low_a: assert property (o_nv_write |=> !o_nv_ready_flag)
    else $error("ready after request");
  prog_len_a: assert property (busy_cnt <= NV_PROG_CYCLES + 2)
    else $error("busy too long");
  busy_ignore_a: assert property (i_rx.valid && !o_nv_ready_flag |=>
    $stable(o_chan_in[0]) && $stable(o_chan_in[3])) else $error("byte taken while busy");
  gc_load_a: assert property (i_rx.gc_update && o_nv_ready_flag |=>
    o_chan_out[0] == $past(o_chan_in[0]) && o_chan_out[1] == $past(o_chan_in[1]) &&
    o_chan_out[2] == $past(o_chan_in[2]) && o_chan_out[3] == $past(o_chan_in[3]))
    else $error("update missed");
  addr_stop_a: assert property ($changed(o_bus_addr) |->
    $past(i_rx.stop) || $past(i_rx.stop, 2) || $past(i_rx.stop, 3)) else $error("addr early");
  load_fall_a: assert property ($fell(i_output_load_n) |-> ##[1:8]
    (o_chan_out[0] == o_chan_in[0] && o_chan_out[3] == o_chan_in[3])) else $error("no load");
  unassigned_a: assert property (cmd_byte && i_rx.data[7:5] == 3'h7 |=>
    $stable(o_chan_in[0]) && $stable(o_chan_out[0])) else $error("bad code acted");
  vref_all_a: assert property (cmd_byte && i_rx.data[7:5] == qdc_pkg::CMD_VREF |=>
    o_chan_out[0].vref == $past(i_rx.data[3]) && o_chan_in[3].vref == $past(i_rx.data[0]))
    else $error("vref wrong");
  gain_all_a: assert property (cmd_byte && i_rx.data[7:5] == qdc_pkg::CMD_GAIN |=>
    o_chan_out[1].gain == $past(i_rx.data[2]) && o_chan_in[2].gain == $past(i_rx.data[1]))
    else $error("gain wrong");
  cfg_no_nv_a: assert property (cmd_byte && i_rx.data[7] |=> !o_nv_write [*2])
    else $error("storage written");
endmodule

// *** bench/qdc_host_model.sv ***
// Purpose: Host model sending whole write transfers as a byte stream.
// Assumes: Bytes follow the start back to back.
// Notes: Released data lines show the inverse of the last byte.
`timescale 1ns/1ns
module qdc_host_model (
  // Clock.
  input wire logic i_sys_clk,
  // Byte stream and load pin.
  output qdc_pkg::qdc_rx_type o_rx,
  output logic o_output_load_n
);
  // Idle lines at time zero.
  initial begin
    o_rx = '0;
    o_output_load_n = 1'b1;
  end
  // Load pin level, changed after an edge.
  task automatic set_load(input logic v);
    @(posedge i_sys_clk);
    o_output_load_n <= v;
  endtask
  // A long eighth-clock low time lets the filtered pin settle before the byte ends.
  task automatic frame(input logic [7:0] b [$], input int fall_at);
    @(posedge i_sys_clk);
    o_rx.start <= 1'b1;
    foreach (b[i]) begin
      @(posedge i_sys_clk);
      o_rx.start <= 1'b0;
      if (i == fall_at) begin
        o_rx.valid <= 1'b0;
        o_rx.bit8_low <= 1'b1;
        o_output_load_n <= 1'b0;
        repeat (8) @(posedge i_sys_clk);
        o_rx.bit8_low <= 1'b0;
      end
      o_rx.valid <= 1'b1;
      o_rx.data <= b[i];
    end
    @(posedge i_sys_clk);
    o_rx.valid <= 1'b0;
    o_rx.data <= ~o_rx.data;
    o_rx.stop <= 1'b1;
    @(posedge i_sys_clk);
    o_rx.stop <= 1'b0;
  endtask
  // One general call software update.
  task automatic gc();
    @(posedge i_sys_clk);
    o_rx.gc_update <= 1'b1;
    @(posedge i_sys_clk);
    o_rx.gc_update <= 1'b0;
  endtask
endmodule

// *** bench/tb_quad_dac_write_command_decoder.sv ***
// Purpose: Self-checking bench of the write command decoder.
// Assumes: Storage time shortened to 20 cycles.
// Notes: Expected channel values are built from the bytes sent.
`timescale 1ns/1ns
module tb_quad_dac_write_command_decoder;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  qdc_pkg::qdc_rx_type rx;
  qdc_pkg::qdc_bus_type bus = '0;
  qdc_pkg::qdc_chan_type chan_in [4];
  qdc_pkg::qdc_chan_type chan_out [4];
  qdc_pkg::qdc_chan_type exp [4];
  qdc_pkg::qdc_chan_type prev [4];
  logic [7:0] rd_data;
  logic [7:0] fw [$];
  logic [3:0] nv_mask;
  logic [3:0] nv_seen = 4'h0;
  logic [2:0] bus_addr;
  logic load_n, irq, nv_write, ready, addr_wr;
  logic addr_wr_seen = 1'b0;
  int n_errors = 0;
  int samples_checked = 0;
  // Clock and a latch of the one-cycle storage request.
  always #4 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) if (nv_write === 1'b1) nv_seen <= nv_mask;
  // The address request is a one-cycle pulse as well, so it is latched too.
  always @(posedge i_sys_clk) if (addr_wr === 1'b1) addr_wr_seen <= 1'b1;
  qdc_host_model i_host (.i_sys_clk(i_sys_clk), .o_rx(rx), .o_output_load_n(load_n));
  qdc_cmd_decoder #(.NV_PROG_CYCLES(20)) i_dut (.i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst), .i_rx(rx), .i_output_load_n(load_n), .i_bus(bus),
    .o_rd_data(rd_data), .o_irq(irq), .o_chan_in(chan_in), .o_chan_out(chan_out),
    .o_bus_addr(bus_addr), .o_nv_write(nv_write), .o_nv_chan_mask(nv_mask),
    .o_nv_addr_write(addr_wr), .o_nv_ready_flag(ready));
  // Compare tasks, one per kind of result.
  task automatic chk_val(input logic [7:0] got, input logic [7:0] want);
    samples_checked++;
    if (got !== want) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  task automatic chk_chan(input qdc_pkg::qdc_chan_type got, input qdc_pkg::qdc_chan_type want);
    samples_checked++;
    if (got !== want) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask
  // Register port: one-cycle strobes, read data in the next cycle only.
  task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_sys_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic reg_chk(input logic [1:0] a, input logic [7:0] want);
    @(posedge i_sys_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_sys_clk);
    bus.rd <= 1'b0;
    #1 chk_val(rd_data, want);
  endtask
  task automatic wait_ready();
    for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge i_sys_clk);
    chk_val({7'h0, ready}, 8'h01);
  endtask
  task automatic summarize();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // Watchdog well past the expected few hundred cycles.
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  // Main sequence.
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    #1 chk_val({7'h0, ready}, 8'h01);
    reg_wr(qdc_pkg::REG_MASK, 8'h01);
    reg_chk(qdc_pkg::REG_MASK, 8'h01);
    reg_chk(2'h3, 8'h00);
    // Fast write with the load pin low, then high.
    for (int k = 0; k < 2; k++) begin
      i_host.set_load(k[0]);
      repeat (4) @(posedge i_sys_clk);
      prev = exp;
      fw = {};
      for (int i = 0; i < 4; i++) begin
        fw.push_back({2'h0, 2'(i + k), 4'(5 * i + k)});
        fw.push_back(8'(40 * i + 9 * k + 3));
        exp[i] = {1'b0, fw[2 * i][5:4], 1'b0, fw[2 * i][3:0], fw[2 * i + 1]};
      end
      i_host.frame(fw, -1);
      repeat (2) @(posedge i_sys_clk);
      for (int i = 0; i < 4; i++) begin
        chk_chan(chan_in[i], exp[i]);
        chk_chan(chan_out[i], k ? prev[i] : exp[i]);
      end
    end
    chk_val({7'h0, irq}, 8'h01);
    reg_chk(qdc_pkg::REG_STATUS, 8'h01);
    reg_chk(qdc_pkg::REG_STATUS, 8'h00);
    chk_val({7'h0, irq}, 8'h00);
    i_host.set_load(1'b0);
    repeat (8) @(posedge i_sys_clk);
    for (int i = 0; i < 4; i++) chk_chan(chan_out[i], exp[i]);
    // Multi-write of C with update low, then B with update high.
    i_host.set_load(1'b1);
    reg_wr(qdc_pkg::REG_MASK, 8'h00);
    i_host.frame({8'h44, 8'h9d, 8'hef, 8'h43, 8'h52, 8'h34}, -1);
    repeat (2) @(posedge i_sys_clk);
    chk_chan(chan_in[2], 16'h9def);
    chk_chan(chan_out[2], 16'h9def);
    chk_chan(chan_in[1], 16'h5234);
    chk_chan(chan_out[1], exp[1]);
    chk_chan(chan_in[3], exp[3]);
    chk_val({7'h0, irq}, 8'h00);
    i_host.gc();
    repeat (2) @(posedge i_sys_clk);
    chk_chan(chan_out[1], 16'h5234);
    // Reference, gain, power-down and an unassigned code.
    i_host.frame({8'h8a}, -1);
    i_host.frame({8'hc5}, -1);
    i_host.frame({8'ha6, 8'hc0}, -1);
    i_host.frame({8'hff, 8'h12, 8'h34}, -1);
    repeat (2) @(posedge i_sys_clk);
    chk_val({6'h0, chan_out[0].pd}, 8'h01);
    chk_val({6'h0, chan_in[2].pd}, 8'h03);
    // Single write with storage; a command while busy is dropped.
    i_host.frame({8'h58, 8'h1a, 8'hbc}, -1);
    repeat (3) @(posedge i_sys_clk);
    chk_val({4'h0, nv_seen}, 8'h01);
    chk_val({7'h0, ready}, 8'h00);
    chk_val({7'h0, addr_wr_seen}, 8'h00);
    i_host.frame({8'h8f}, -1);
    wait_ready();
    chk_val({7'h0, chan_out[3].vref}, 8'h00);
    // Address write with the load pin falling in the eighth clock of byte two.
    // Byte two of the transfer is the command byte, the first on the stream.
    i_host.frame({8'h60, 8'h14, 8'h00}, 0);
    repeat (3) @(posedge i_sys_clk);
    chk_val({5'h0, bus_addr}, 8'h05);
    wait_ready();
    reg_chk(qdc_pkg::REG_STATE, 8'h0d);
    chk_val({7'h0, addr_wr_seen}, 8'h01);
    // Every event kind has fired since the last clearing read.
    reg_chk(qdc_pkg::REG_STATUS, 8'h0f);
    summarize();
  end
endmodule
bind qdc_cmd_decoder qdc_cmd_props #(.NV_PROG_CYCLES(NV_PROG_CYCLES)) i_props (
  .i_sys_clk, .i_sys_rst, .i_rx, .i_output_load_n, .o_chan_in, .o_chan_out,
  .o_bus_addr, .o_nv_write, .o_nv_ready_flag);

// *** verilog/qdc_cmd_decoder.sv ***
// Purpose: Decodes write commands for a four-channel 12-bit converter.
// Assumes: A serial front end delivers each received byte as a one-cycle pulse at its
//   acknowledge clock, plus start, stop, eighth-bit low time and general call update.
// Notes: Input and output registers of each channel are held here; storage itself is
//   outside and is told when and what to program.
`timescale 1ns/1ns
module qdc_cmd_decoder #(
  parameter int unsigned NV_PROG_CYCLES = qdc_pkg::NV_PROG_CYCLES
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Byte stream from the serial front end.
  input wire qdc_pkg::qdc_rx_type i_rx,
  // Output load pin, active low, asynchronous.
  input wire logic i_output_load_n,
  // Register port.
  input wire qdc_pkg::qdc_bus_type i_bus,
  output logic [7:0] o_rd_data,
  output logic o_irq,
  // Channel registers.
  output qdc_pkg::qdc_chan_type o_chan_in [4],
  output qdc_pkg::qdc_chan_type o_chan_out [4],
  output logic [2:0] o_bus_addr,
  // Storage programming request and ready flag.
  output logic o_nv_write,
  output logic [3:0] o_nv_chan_mask,
  output logic o_nv_addr_write,
  output logic o_nv_ready_flag
);

  qdc_pkg::qdc_state_type state;
  logic load_level;
  logic load_prev;
  logic load_fall;
  logic nv_busy;
  logic nv_done;
  logic [1:0] chan_idx;
  logic fast_ld_low;
  logic [7:0] prev_byte;
  logic [7:0] cmd_byte;
  logic fall_in_bit8;
  logic addr_ok;
  logic addr_pend;
  logic [2:0] new_addr;
  logic addr_apply;
  logic [2:0] cmd_type_bits;
  logic [1:0] write_func_bits;
  logic is_fast;
  logic cmd_ignored;
  logic cmd_done;
  logic nv_start;
  logic [3:0] nv_mask;
  logic [3:0] out_ld;
  logic [3:0] status;
  logic [3:0] mask;
  logic [3:0] status_set;
  qdc_pkg::qdc_chan_type next_in [4];

  // The load pin is filtered before any edge is taken from it.
  qdc_pin_sync #(
    .RST_LEVEL(1'b1)
  ) u_load_sync (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_output_load_n),
    .o_level(load_level)
  );

  // Programming time of the storage.
  qdc_nv_timer #(
    .CYCLES(NV_PROG_CYCLES)
  ) u_nv_timer (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_start(nv_start),
    .o_busy(nv_busy),
    .o_done(nv_done)
  );

  // Falling edge of the filtered load pin.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      load_prev <= 1'b1;
    end else begin
      load_prev <= load_level;
    end
  end

  assign load_fall = load_prev && !load_level;

  // Command fields of the byte on the stream.
  assign cmd_type_bits = i_rx.data[qdc_pkg::CMD_MSB:qdc_pkg::CMD_LSB];
  assign write_func_bits = i_rx.data[qdc_pkg::FUNC_MSB:qdc_pkg::FUNC_LSB];
  assign is_fast = (cmd_type_bits[2:1] == qdc_pkg::CMD_FAST_TOP);

  // Command sequencer: one state per expected byte of the transfer.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      state <= qdc_pkg::S_IDLE;
      chan_idx <= 2'h0;
    end else if (i_rx.stop) begin
      state <= qdc_pkg::S_IDLE;
    end else if (i_rx.start) begin
      // A start during programming leaves the whole transfer unexecuted.
      state <= nv_busy ? qdc_pkg::S_DRAIN : qdc_pkg::S_CMD;
      chan_idx <= 2'h0;
    end else if (i_rx.valid) begin
      unique case (state)
        qdc_pkg::S_CMD: begin
          if (is_fast) begin
            state <= qdc_pkg::S_FAST_LO;
          end else if (cmd_type_bits == qdc_pkg::CMD_WRITE &&
                       write_func_bits != qdc_pkg::FUNC_BAD) begin
            chan_idx <= i_rx.data[qdc_pkg::SEL_MSB:qdc_pkg::SEL_LSB];
            state <= qdc_pkg::S_MW_HI;
          end else if (cmd_type_bits == qdc_pkg::CMD_ADDR) begin
            state <= qdc_pkg::S_ADDR_NEW;
          end else if (cmd_type_bits == qdc_pkg::CMD_PD) begin
            state <= qdc_pkg::S_PD_LO;
          end else begin
            state <= qdc_pkg::S_DRAIN;
          end
        end
        qdc_pkg::S_FAST_HI: state <= qdc_pkg::S_FAST_LO;
        qdc_pkg::S_FAST_LO: begin
          chan_idx <= chan_idx + 2'h1;
          state <= (chan_idx == qdc_pkg::LAST_CHAN) ? qdc_pkg::S_DRAIN : qdc_pkg::S_FAST_HI;
        end
        qdc_pkg::S_MW_HI: state <= qdc_pkg::S_MW_LO;
        qdc_pkg::S_MW_LO: begin
          unique case (cmd_byte[qdc_pkg::FUNC_MSB:qdc_pkg::FUNC_LSB])
            qdc_pkg::FUNC_MULTI: state <= qdc_pkg::S_CMD;
            qdc_pkg::FUNC_SEQ: begin
              chan_idx <= chan_idx + 2'h1;
              state <= (chan_idx == qdc_pkg::LAST_CHAN) ? qdc_pkg::S_DRAIN : qdc_pkg::S_MW_HI;
            end
            default: state <= qdc_pkg::S_DRAIN;
          endcase
        end
        qdc_pkg::S_PD_LO: state <= qdc_pkg::S_DRAIN;
        qdc_pkg::S_ADDR_NEW: state <= qdc_pkg::S_ADDR_CONF;
        qdc_pkg::S_ADDR_CONF: state <= qdc_pkg::S_DRAIN;
        qdc_pkg::S_IDLE, qdc_pkg::S_DRAIN: state <= state;
        default: state <= qdc_pkg::S_IDLE;
      endcase
    end
  end

  // Byte holders: the previous byte carries the upper half of each pair.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      prev_byte <= 8'h00;
      cmd_byte <= 8'h00;
    end else if (i_rx.valid) begin
      prev_byte <= i_rx.data;
      if (state == qdc_pkg::S_CMD) begin
        cmd_byte <= i_rx.data;
      end
    end
  end

  // The load level at the start decides how a fast write reaches the outputs.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      fast_ld_low <= 1'b0;
    end else if (i_rx.start) begin
      fast_ld_low <= !load_level;
    end
  end

  // Address write qualification by the load pin around byte two and three.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      fall_in_bit8 <= 1'b0;
      addr_ok <= 1'b0;
      addr_pend <= 1'b0;
      new_addr <= qdc_pkg::BUS_ADDR_RST;
    end else begin
      if (i_rx.valid) begin
        fall_in_bit8 <= 1'b0;
      end else if (load_fall && i_rx.bit8_low) begin
        fall_in_bit8 <= 1'b1;
      end
      if (i_rx.start || i_rx.stop) begin
        addr_ok <= 1'b0;
        addr_pend <= 1'b0;
      end else if (i_rx.valid && state == qdc_pkg::S_CMD) begin
        addr_ok <= (cmd_type_bits == qdc_pkg::CMD_ADDR) &&
                   (fall_in_bit8 || (load_fall && i_rx.bit8_low));
      end else if (state == qdc_pkg::S_ADDR_NEW && load_level) begin
        addr_ok <= 1'b0;
      end else if (i_rx.valid && state == qdc_pkg::S_ADDR_NEW) begin
        new_addr <= i_rx.data[qdc_pkg::NADDR_MSB:qdc_pkg::NADDR_LSB];
        addr_pend <= addr_ok;
      end
    end
  end

  // The new address takes effect only after the stop condition.
  assign addr_apply = i_rx.stop && addr_pend && !nv_busy;

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_bus_addr <= qdc_pkg::BUS_ADDR_RST;
    end else if (addr_apply) begin
      o_bus_addr <= new_addr;
    end
  end

  // Next value of every input register, output loads and storage requests.
  always_comb begin
    cmd_ignored = 1'b0;
    cmd_done = 1'b0;
    nv_mask = 4'h0;
    for (int c = 0; c < 4; c++) begin
      next_in[c] = o_chan_in[c];
      // Pin fall, and general call while storage is not busy, move all four channels at once.
      out_ld[c] = load_fall || (i_rx.gc_update && !nv_busy);
    end
    if (i_rx.gc_update && nv_busy) begin
      cmd_ignored = 1'b1;
    end
    if (i_rx.start && nv_busy) begin
      cmd_ignored = 1'b1;
    end
    if (i_rx.valid) begin
      unique case (state)
        qdc_pkg::S_CMD: begin
          if (!is_fast) begin
            unique case (cmd_type_bits)
              qdc_pkg::CMD_VREF, qdc_pkg::CMD_GAIN: begin
                cmd_done = 1'b1;
                for (int c = 0; c < 4; c++) begin
                  if (cmd_type_bits == qdc_pkg::CMD_VREF) begin
                    next_in[c].vref = i_rx.data[3 - c];
                  end else begin
                    next_in[c].gain = i_rx.data[3 - c];
                  end
                  out_ld[c] = 1'b1;
                end
              end
              qdc_pkg::CMD_WRITE: cmd_ignored = (write_func_bits == qdc_pkg::FUNC_BAD);
              qdc_pkg::CMD_ADDR, qdc_pkg::CMD_PD: cmd_done = 1'b0;
              default: cmd_ignored = 1'b1;
            endcase
          end
        end
        qdc_pkg::S_FAST_LO: begin
          for (int c = 0; c < 4; c++) begin
            if (2'(c) == chan_idx) begin
              // Reference and gain stay; the update bit has no place here.
              next_in[c].pd = prev_byte[qdc_pkg::FPD_MSB:qdc_pkg::FPD_LSB];
              next_in[c].code = {prev_byte[3:0], i_rx.data};
              out_ld[c] = out_ld[c] || fast_ld_low;
            end
          end
          cmd_done = (chan_idx == qdc_pkg::LAST_CHAN);
        end
        qdc_pkg::S_MW_LO: begin
          for (int c = 0; c < 4; c++) begin
            if (2'(c) == chan_idx) begin
              next_in[c].vref = prev_byte[qdc_pkg::VREF_BIT];
              next_in[c].pd = prev_byte[qdc_pkg::PD_MSB:qdc_pkg::PD_LSB];
              next_in[c].gain = prev_byte[qdc_pkg::GAIN_BIT];
              next_in[c].code = {prev_byte[3:0], i_rx.data};
              out_ld[c] = out_ld[c] || !load_level || !cmd_byte[qdc_pkg::UPD_BIT];
            end
          end
          unique case (cmd_byte[qdc_pkg::FUNC_MSB:qdc_pkg::FUNC_LSB])
            qdc_pkg::FUNC_SEQ: begin
              // Storage takes every channel from the start channel to D together.
              for (int c = 0; c < 4; c++) begin
                nv_mask[c] = (chan_idx == qdc_pkg::LAST_CHAN) &&
                             (2'(c) >= cmd_byte[qdc_pkg::SEL_MSB:qdc_pkg::SEL_LSB]);
              end
            end
            qdc_pkg::FUNC_SINGLE: nv_mask[chan_idx] = 1'b1;
            default: nv_mask = 4'h0;
          endcase
          cmd_done = 1'b1;
        end
        qdc_pkg::S_PD_LO: begin
          next_in[0].pd = prev_byte[3:2];
          next_in[1].pd = prev_byte[1:0];
          next_in[2].pd = i_rx.data[7:6];
          next_in[3].pd = i_rx.data[5:4];
          out_ld = 4'hf;
          cmd_done = 1'b1;
        end
        default: cmd_done = 1'b0;
      endcase
    end
  end

  assign nv_start = (|nv_mask) || addr_apply;

  // One input and one output register per channel.
  for (genvar g = 0; g < 4; g++) begin : g_chan
    always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
        o_chan_in[g] <= '0;
        o_chan_out[g] <= '0;
      end else begin
        o_chan_in[g] <= next_in[g];
        if (out_ld[g]) begin
          o_chan_out[g] <= next_in[g];
        end
      end
    end
  end

  // Storage request and ready flag, both registered for clean outputs.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_nv_write <= 1'b0;
      o_nv_chan_mask <= 4'h0;
      o_nv_addr_write <= 1'b0;
      o_nv_ready_flag <= 1'b1;
    end else begin
      o_nv_write <= nv_start;
      o_nv_chan_mask <= nv_mask;
      o_nv_addr_write <= addr_apply;
      o_nv_ready_flag <= !(nv_busy || nv_start);
    end
  end

  // Sticky events; a set in the clearing cycle survives the read.
  always_comb begin
    status_set = 4'h0;
    status_set[qdc_pkg::ST_DONE] = cmd_done;
    status_set[qdc_pkg::ST_NV_DONE] = nv_done;
    status_set[qdc_pkg::ST_IGNORED] = cmd_ignored;
    status_set[qdc_pkg::ST_ADDR] = addr_apply;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      status <= qdc_pkg::STATUS_RST;
    end else if (i_bus.rd && i_bus.addr == qdc_pkg::REG_STATUS) begin
      status <= status_set;
    end else begin
      status <= status | status_set;
    end
  end

  // Mask register written by software.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      mask <= qdc_pkg::MASK_RST;
    end else if (i_bus.wr && i_bus.addr == qdc_pkg::REG_MASK) begin
      mask <= i_bus.wdata[3:0];
    end
  end

  // Read data one cycle after the strobe; unmapped indices read zero.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        qdc_pkg::REG_STATUS: o_rd_data <= {4'h0, status};
        qdc_pkg::REG_MASK: o_rd_data <= {4'h0, mask};
        qdc_pkg::REG_STATE: o_rd_data <= {3'h0, load_level, o_nv_ready_flag, o_bus_addr};
        default: o_rd_data <= 8'h00;
      endcase
    end else begin
      o_rd_data <= 8'h00;
    end
  end

  // Level interrupt, one cycle behind the status bits.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(status & mask);
    end
  end

endmodule

// *** verilog/qdc_nv_timer.sv ***
// Purpose: Holds the storage busy state for one programming cycle.
// Assumes: A start pulse never arrives while busy.
// Notes: The length is a parameter so that a simulation can shorten it.
`timescale 1ns/1ns
module qdc_nv_timer #(
  parameter int unsigned CYCLES = qdc_pkg::NV_PROG_CYCLES
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Control and status.
  input wire logic i_start,
  output logic o_busy,
  output logic o_done
);

  logic [31:0] count;

  // Count down from the start pulse and pulse done at the end.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      count <= 32'h0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start && !o_busy) begin
        count <= 32'(CYCLES - 1);
        o_busy <= 1'b1;
      end else if (o_busy) begin
        if (count == 32'h0) begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end else begin
          count <= count - 32'h1;
        end
      end
    end
  end

endmodule

// *** verilog/qdc_pin_sync.sv ***
// Purpose: Brings an asynchronous pin into the system clock domain.
// Assumes: The pin may change at any time relative to the clock.
// Notes: A change is accepted only once the second and third stages agree.
`timescale 1ns/1ns
module qdc_pin_sync #(
  parameter logic RST_LEVEL = 1'b1
) (
  // Clock and reset.
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  // Pin and filtered level.
  input wire logic i_pin,
  output logic o_level
);

  logic s1;
  logic s2;
  logic s3;

  // Three stages; the first is read only by the second.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      s1 <= RST_LEVEL;
      s2 <= RST_LEVEL;
      s3 <= RST_LEVEL;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accepting only agreeing stages rejects a single-cycle glitch.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_level <= RST_LEVEL;
    end else if (s2 == s3) begin
      o_level <= s3;
    end
  end

endmodule

// *** verilog/qdc_pkg.sv ***
// Purpose: Shared constants and types of the quad converter write command decoder.
// Assumes: One 125 MHz system clock; the serial front end delivers whole bytes.
// Notes: Command field positions follow the command byte layout; all counts derive here.
package qdc_pkg;

  // Clock rate and storage programming time.
  localparam int unsigned SYS_CLK_MHZ = 125;
  localparam int unsigned NV_PROG_TIME_US = 50;
  localparam int unsigned NV_PROG_CYCLES = NV_PROG_TIME_US * SYS_CLK_MHZ;

  // Command type codes (three bits) and write function codes (two bits).
  localparam logic [1:0] CMD_FAST_TOP = 2'h0;
  localparam logic [2:0] CMD_WRITE = 3'h2;
  localparam logic [2:0] CMD_ADDR = 3'h3;
  localparam logic [2:0] CMD_VREF = 3'h4;
  localparam logic [2:0] CMD_PD = 3'h5;
  localparam logic [2:0] CMD_GAIN = 3'h6;
  localparam logic [1:0] FUNC_MULTI = 2'h0;
  localparam logic [1:0] FUNC_BAD = 2'h1;
  localparam logic [1:0] FUNC_SEQ = 2'h2;
  localparam logic [1:0] FUNC_SINGLE = 2'h3;
  localparam logic [1:0] LAST_CHAN = 2'h3;

  // Field positions in the command byte and in the first data byte.
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 5;
  localparam int FUNC_MSB = 4;
  localparam int FUNC_LSB = 3;
  localparam int SEL_MSB = 2;
  localparam int SEL_LSB = 1;
  localparam int UPD_BIT = 0;
  localparam int VREF_BIT = 7;
  localparam int PD_MSB = 6;
  localparam int PD_LSB = 5;
  localparam int GAIN_BIT = 4;
  localparam int FPD_MSB = 5;
  localparam int FPD_LSB = 4;
  localparam int NADDR_MSB = 4;
  localparam int NADDR_LSB = 2;

  // Register indices, status bit positions and reset values.
  localparam logic [1:0] REG_STATUS = 2'h0;
  localparam logic [1:0] REG_MASK = 2'h1;
  localparam logic [1:0] REG_STATE = 2'h2;
  localparam int ST_DONE = 0;
  localparam int ST_NV_DONE = 1;
  localparam int ST_IGNORED = 2;
  localparam int ST_ADDR = 3;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [2:0] BUS_ADDR_RST = 3'h0;

  // One converter channel: reference, power-down, gain and code.
  typedef struct packed {
    logic vref;
    logic [1:0] pd;
    logic gain;
    logic [11:0] code;
  } qdc_chan_type;

  // Byte stream from the serial front end.
  typedef struct packed {
    logic start;
    logic stop;
    logic valid;
    logic [7:0] data;
    logic bit8_low;
    logic gc_update;
  } qdc_rx_type;

  // Plain register port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [1:0] addr;
    logic [7:0] wdata;
  } qdc_bus_type;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_CMD = 4'h1,
    S_FAST_HI = 4'h2,
    S_FAST_LO = 4'h3,
    S_MW_HI = 4'h4,
    S_MW_LO = 4'h5,
    S_PD_LO = 4'h6,
    S_ADDR_NEW = 4'h7,
    S_ADDR_CONF = 4'h8,
    S_DRAIN = 4'h9
  } qdc_state_type;

endpackage
